// file: addr_decode_pkg.sv
package addr_decode_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000; // Program flash window
  localparam logic [31:0] FLASH_LAST = 32'h07FF_FFFF;
  localparam logic [31:0] VECTOR_BYTES = 32'h0000_00C4; // Exception vector span, 196 bytes
  localparam logic [31:0] SRAM_L_BASE = 32'h1FFF_F000; // Lower RAM window
  localparam logic [31:0] SRAM_L_LAST = 32'h1FFF_FFFF;
  localparam logic [31:0] SRAM_U_BASE = 32'h2000_0000; // Upper RAM window
  localparam logic [31:0] SRAM_U_LAST = 32'h2000_2FFF;
  localparam logic [31:0] BRIDGE_BASE = 32'h4000_0000; // Bridge slots 0..127
  localparam logic [31:0] BRIDGE_LAST = 32'h4007_FFFF;
  localparam logic [31:0] GPIO_BASE = 32'h400F_F000; // Primary GPIO bridge base
  localparam logic [31:0] GPIO_LAST = 32'h400F_FFFF;
  localparam logic [31:0] ALIAS_BASE = 32'h4400_0000; // Atomic bit alias region
  localparam logic [31:0] ALIAS_LAST = 32'h5FFF_FFFF;
  localparam logic [31:0] PPB_BASE = 32'hE000_0000; // Core private peripherals
  localparam logic [31:0] PPB_LAST = 32'hE00F_FFFF;
  localparam logic [31:0] TRACE_BASE = 32'hF000_0000; // First of four debug windows
  localparam logic [31:0] TRACE_LAST = 32'hF000_3FFF;
  localparam logic [31:0] IO_BASE = 32'hF800_0000; // Single cycle I/O window
  localparam logic [31:0] IO_LAST = 32'hFFFF_FFFF;
  localparam logic [31:0] OFFSET_MASK_4K = 32'h0000_0FFF; // Offset inside a 4 KB window
  localparam logic [31:0] OFFSET_MASK_1M = 32'h000F_FFFF; // Offset inside the bridge space

  // ----------------------------------------------------------------
  // Bridge slot fields
  // ----------------------------------------------------------------
  localparam int SLOT_LSB = 12; // Slot number position
  localparam int SLOT_W = 7; // Slots 0..127
  localparam int NUM_SLOTS = 128;
  localparam int ALIAS_SLOT_MSB = 19; // Set means slot above 127
  localparam int WIN_SEL_LSB = 12; // Debug window select
  localparam int WIN_SEL_W = 2;
  localparam logic [6:0] GPIO_SLOT = 7'h0F; // Slot aliased onto the GPIO

  // ----------------------------------------------------------------
  // Trim bytes
  // ----------------------------------------------------------------
  localparam logic [31:0] TRIM_WORD_ADDR = 32'h0000_03FC; // Word holding the trim bytes
  localparam int TRIM_FINE_BIT = 16; // Byte 0x3FE, bit 0
  localparam int TRIM_FAST_LSB = 17; // Byte 0x3FE, bits 4:1
  localparam int TRIM_FAST_W = 4;
  localparam int TRIM_COARSE_LSB = 24; // Byte 0x3FF
  localparam int TRIM_COARSE_W = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    MASTER_CORE = 1'b0,
    MASTER_DMA = 1'b1
  } master_type;

  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_FLASH = 4'h1,
    TGT_SRAM_L = 4'h2,
    TGT_SRAM_U = 4'h3,
    TGT_BRIDGE = 4'h4,
    TGT_GPIO_BRIDGE = 4'h5,
    TGT_GPIO_IO = 4'h6,
    TGT_BIT_ALIAS = 4'h7,
    TGT_PRIVATE = 4'h8,
    TGT_TRACE_BUF = 4'h9,
    TGT_TRACE_WP = 4'hA,
    TGT_ROM_TABLE = 4'hB,
    TGT_MISC_CTRL = 4'hC
  } target_type;

  typedef struct packed {
    logic valid; // Request present this cycle
    master_type master; // Issuing master
    logic write; // High for a write
    logic [31:0] addr; // Byte address
  } req_type;

  typedef struct packed {
    logic valid; // A slave is selected
    target_type target; // Selected slave
    logic [31:0] offset; // Address passed to the slave
    logic vector; // Access hits the vector span
    logic full_atomic; // Every atomic operation allowed
  } route_type;

  typedef struct packed {
    logic fine; // Slow oscillator fine trim
    logic [TRIM_FAST_W-1:0] fast; // Fast oscillator trim
    logic [TRIM_COARSE_W-1:0] coarse; // Slow oscillator coarse trim
  } trim_type;

endpackage : addr_decode_pkg

// file: osc_trim_capture.sv
`timescale 1ns/1ps
module osc_trim_capture (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic trim_read_i,
  input wire logic flash_rvalid_i,
  input wire logic [31:0] flash_rdata_i,
  output addr_decode_pkg::trim_type trim_o,
  output logic trim_valid_o
);
  import addr_decode_pkg::*;

  logic pending_q; // Trim word read under way
  trim_type trim_q; // Captured trim fields
  logic valid_q; // Trim fields loaded once

  // ----------------------------------------------------------------
  // Pending read tracking
  // ----------------------------------------------------------------
  // Set by a new read, cleared by the returning beat; set wins
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pending_q <= 1'b0;
    end else if (trim_read_i) begin
      pending_q <= 1'b1;
    end else if (flash_rvalid_i) begin
      pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Field capture
  // ----------------------------------------------------------------
  // Split the trim byte lanes out of the returned word
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      trim_q <= '0;
      valid_q <= 1'b0;
    end else if (pending_q && flash_rvalid_i) begin
      trim_q.fine <= flash_rdata_i[TRIM_FINE_BIT];
      trim_q.fast <= flash_rdata_i[TRIM_FAST_LSB +: TRIM_FAST_W];
      trim_q.coarse <= flash_rdata_i[TRIM_COARSE_LSB +: TRIM_COARSE_W];
      valid_q <= 1'b1;
    end
  end

  assign trim_o = trim_q;
  assign trim_valid_o = valid_q;

endmodule : osc_trim_capture

// file: system_address_decoder.sv
`timescale 1ns/1ps
module system_address_decoder #(
  parameter logic [31:0] FLASH_FITTED = 32'h0002_0000, // Bytes of flash fitted
  parameter logic [31:0] SRAM_L_FITTED = 32'h0000_1000, // Bytes in the lower half
  parameter logic [31:0] SRAM_U_FITTED = 32'h0000_3000, // Bytes in the upper half
  parameter logic [127:0] SLOT_IMPL = {128{1'b1}} // Slots that hold a module
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input addr_decode_pkg::req_type req_i,
  input wire logic flash_cmd_busy_i,
  input wire logic [127:0] slot_clk_en_i,
  input wire logic flash_rvalid_i,
  input wire logic [31:0] flash_rdata_i,
  output addr_decode_pkg::route_type route_o,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output addr_decode_pkg::trim_type trim_o,
  output logic trim_valid_o
);
  import addr_decode_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inclusive window test
  function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  // Bridge slot enabled: module present and its clock on
  function automatic logic slot_ok(input logic [SLOT_W-1:0] s, input logic [127:0] en);
    slot_ok = SLOT_IMPL[s] && en[s];
  endfunction : slot_ok

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  route_type route_d; // Combinational route
  logic err_d; // Combinational error verdict
  logic is_core; // Core is the master
  logic [SLOT_W-1:0] slot; // Bridge slot of a direct access
  logic [SLOT_W-1:0] alias_slot; // Bridge slot of an alias access
  logic [WIN_SEL_W-1:0] win_sel; // Debug window index

  assign is_core = (req_i.master == MASTER_CORE);
  assign slot = req_i.addr[SLOT_LSB +: SLOT_W];
  assign alias_slot = req_i.addr[SLOT_LSB +: SLOT_W];
  assign win_sel = req_i.addr[WIN_SEL_LSB +: WIN_SEL_W];

  // Map each window onto its slave, or onto an error
  always_comb begin
    route_d = '0;
    route_d.target = TGT_NONE;
    err_d = 1'b0;
    if (req_i.valid) begin
      if (in_win(req_i.addr, FLASH_BASE, FLASH_LAST)) begin
        // Flash open to every master
        route_d.target = TGT_FLASH;
        route_d.offset = req_i.addr - FLASH_BASE;
        route_d.vector = (req_i.addr < VECTOR_BYTES);
        if (req_i.addr >= FLASH_FITTED) begin
          err_d = 1'b1;
        end else if (!req_i.write && flash_cmd_busy_i) begin
          err_d = 1'b1;
        end
      end else if (in_win(req_i.addr, SRAM_L_BASE, SRAM_L_LAST)) begin
        // Lower half ends just below the upper base
        route_d.target = TGT_SRAM_L;
        route_d.offset = req_i.addr - SRAM_L_BASE;
        err_d = (req_i.addr < (SRAM_U_BASE - SRAM_L_FITTED));
      end else if (in_win(req_i.addr, SRAM_U_BASE, SRAM_U_LAST)) begin
        // Upper half starts at its base
        route_d.target = TGT_SRAM_U;
        route_d.offset = req_i.addr - SRAM_U_BASE;
        err_d = (req_i.addr >= (SRAM_U_BASE + SRAM_U_FITTED));
      end else if (in_win(req_i.addr, BRIDGE_BASE, BRIDGE_LAST)) begin
        // Slot 15 is the GPIO alias, full atomic support
        if (slot == GPIO_SLOT) begin
          route_d.target = TGT_GPIO_BRIDGE;
          route_d.full_atomic = 1'b1;
        end else begin
          route_d.target = TGT_BRIDGE;
          err_d = !slot_ok(slot, slot_clk_en_i);
        end
        route_d.offset = req_i.addr & OFFSET_MASK_1M;
      end else if (in_win(req_i.addr, GPIO_BASE, GPIO_LAST)) begin
        // Primary base: core and DMA, partial atomic support
        route_d.target = TGT_GPIO_BRIDGE;
        route_d.full_atomic = 1'b0;
        route_d.offset = req_i.addr & OFFSET_MASK_4K;
      end else if (in_win(req_i.addr, ALIAS_BASE, ALIAS_LAST)) begin
        // Alias passes the whole address on; slot above 127 is refused
        route_d.target = TGT_BIT_ALIAS;
        route_d.offset = req_i.addr;
        route_d.full_atomic = 1'b1;
        if (!is_core || req_i.addr[ALIAS_SLOT_MSB]) begin
          err_d = 1'b1;
        end else if (alias_slot != GPIO_SLOT) begin
          err_d = !slot_ok(alias_slot, slot_clk_en_i);
        end
      end else if (in_win(req_i.addr, PPB_BASE, PPB_LAST)) begin
        // Private peripherals are core only
        route_d.target = TGT_PRIVATE;
        route_d.offset = req_i.addr - PPB_BASE;
        err_d = !is_core;
      end else if (in_win(req_i.addr, TRACE_BASE, TRACE_LAST)) begin
        // Four consecutive 4 KB windows
        unique case (win_sel)
          2'h0: begin
            route_d.target = TGT_TRACE_BUF;
          end
          2'h1: begin
            route_d.target = TGT_TRACE_WP;
          end
          2'h2: begin
            route_d.target = TGT_ROM_TABLE;
          end
          2'h3: begin
            route_d.target = TGT_MISC_CTRL;
          end
        endcase
        route_d.offset = req_i.addr & OFFSET_MASK_4K;
        err_d = !is_core;
      end else if (in_win(req_i.addr, IO_BASE, IO_LAST)) begin
        // Direct port, no bridge stage
        route_d.target = TGT_GPIO_IO;
        route_d.offset = req_i.addr & OFFSET_MASK_4K;
        err_d = !is_core;
      end else begin
        // Reserved hole
        err_d = 1'b1;
      end
      // An errored cycle selects nothing
      if (err_d) begin
        route_d.valid = 1'b0;
        route_d.target = TGT_NONE;
      end else begin
        route_d.valid = 1'b1;
      end
    end
  end

  // Select reaches the slave in the request cycle
  assign route_o = route_d;

  // ----------------------------------------------------------------
  // Error response
  // ----------------------------------------------------------------
  logic rsp_valid_q; // Response beat for the decoder itself
  logic rsp_err_q; // Beat is an error termination

  // Decoder answers errors one cycle after the request
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rsp_valid_q <= 1'b0;
      rsp_err_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_i.valid && err_d;
      rsp_err_q <= req_i.valid && err_d;
    end
  end

  // Slave data is never blanked; the master drops it on error
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_err_o = rsp_err_q;

  // ----------------------------------------------------------------
  // Trim capture
  // ----------------------------------------------------------------
  logic trim_read; // Good read of the trim word

  assign trim_read = route_d.valid && !req_i.write && (route_d.target == TGT_FLASH) &&
                     (req_i.addr == TRIM_WORD_ADDR);

  osc_trim_capture u_trim (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .trim_read_i(trim_read),
    .flash_rvalid_i(flash_rvalid_i),
    .flash_rdata_i(flash_rdata_i),
    .trim_o(trim_o),
    .trim_valid_o(trim_valid_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Core reaches the port window directly
  a_io_zero_wait: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && is_core && req_i.addr >= IO_BASE) |-> route_o.target == TGT_GPIO_IO)
    else $error("core I/O window not routed to GPIO");

  // Other masters are turned away from the port window
  a_io_dma_refused: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && !is_core && req_i.addr >= IO_BASE)
    |-> (!route_o.valid ##1 (rsp_valid_o && rsp_err_o)))
    else $error("DMA access to the I/O window not refused");

  // Slot 15 alias lands on the GPIO with every atomic operation
  a_gpio_alias_route: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && in_win(req_i.addr, BRIDGE_BASE, BRIDGE_LAST) && slot == GPIO_SLOT)
    |-> (route_o.target == TGT_GPIO_BRIDGE && route_o.full_atomic))
    else $error("slot 15 not routed to GPIO");

  // Primary GPIO base only offers the partial atomic set
  a_gpio_primary: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && in_win(req_i.addr, GPIO_BASE, GPIO_LAST))
    |-> (route_o.target == TGT_GPIO_BRIDGE && !route_o.full_atomic))
    else $error("primary GPIO base misrouted");

  // Bit alias region is for the core alone
  a_alias_core_only: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && !is_core && in_win(req_i.addr, ALIAS_BASE, ALIAS_LAST))
    |=> (rsp_valid_o && rsp_err_o))
    else $error("DMA alias access not refused");

  // Alias addresses past slot 127 select nothing
  a_alias_slot_range: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && in_win(req_i.addr, ALIAS_BASE, ALIAS_LAST) && req_i.addr[ALIAS_SLOT_MSB])
    |-> (!route_o.valid ##1 (rsp_valid_o && rsp_err_o)))
    else $error("alias beyond slot 127 not refused");

  // Vector flag stays inside the vector span
  a_vector_span: assert property (@(posedge mclk_i) disable iff (srst_i)
    (route_o.valid && route_o.vector) |-> (route_o.target == TGT_FLASH && req_i.addr < VECTOR_BYTES))
    else $error("vector flag outside first 196 bytes");

  // Flash beyond the fitted size ends in an error
  a_flash_over: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && req_i.addr >= FLASH_FITTED && req_i.addr <= FLASH_LAST)
    |-> (!route_o.valid ##1 rsp_err_o))
    else $error("unfitted flash not error terminated");

  // Reads collide with a running flash command
  a_flash_collide: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && !req_i.write && flash_cmd_busy_i && req_i.addr <= FLASH_LAST)
    |=> rsp_err_o)
    else $error("flash read collision not errored");

  // Upper RAM picks up where lower RAM stops
  a_ram_contig: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && req_i.addr == SRAM_U_BASE) |-> route_o.target == TGT_SRAM_U)
    else $error("upper RAM does not start at its base");

  // Lower RAM below the fitted part errors
  a_ram_lower_fit: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && in_win(req_i.addr, SRAM_L_BASE, SRAM_L_LAST) &&
     req_i.addr < (SRAM_U_BASE - SRAM_L_FITTED)) |=> (rsp_valid_o && rsp_err_o))
    else $error("unfitted lower RAM not error terminated");

  // Upper RAM above the fitted part errors
  a_ram_upper_fit: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && in_win(req_i.addr, SRAM_U_BASE, SRAM_U_LAST) &&
     req_i.addr >= (SRAM_U_BASE + SRAM_U_FITTED)) |=> (rsp_valid_o && rsp_err_o))
    else $error("unfitted upper RAM not error terminated");

  // Fourth debug window is the misc control unit
  a_debug_windows: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && is_core && req_i.addr == (TRACE_LAST & ~OFFSET_MASK_4K))
    |-> route_o.target == TGT_MISC_CTRL)
    else $error("fourth debug window misrouted");

  // Debug windows refuse other masters
  a_debug_core_only: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && !is_core && in_win(req_i.addr, TRACE_BASE, TRACE_LAST))
    |-> (!route_o.valid ##1 (rsp_valid_o && rsp_err_o)))
    else $error("DMA debug window access not refused");

  // Absent or gated bridge slot errors
  a_slot_gated: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && in_win(req_i.addr, BRIDGE_BASE, BRIDGE_LAST) && slot != GPIO_SLOT &&
     (!SLOT_IMPL[slot] || !slot_clk_en_i[slot])) |=> (rsp_valid_o && rsp_err_o))
    else $error("absent or gated slot not error terminated");

  // Errored access never selects a slave
  a_reserved_none: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && err_d) |-> (route_o.target == TGT_NONE ##1 (rsp_valid_o && rsp_err_o)))
    else $error("errored access reached a slave");

  // Every error beat has a cause one cycle back
  a_err_single: assert property (@(posedge mclk_i) disable iff (srst_i)
    rsp_err_o |-> $past(req_i.valid && err_d))
    else $error("error beat without cause");

  // Trim fields load only on a flash beat
  a_trim_beat: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(trim_valid_o) |-> $past(flash_rvalid_i))
    else $error("trim loaded without a flash beat");

endmodule : system_address_decoder

// file: bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic rsp_err_i,
  output addr_decode_pkg::req_type req_o
);
  import addr_decode_pkg::*;
  // ------------------------------------------------------------
  // Request drive and read bookkeeping
  // ------------------------------------------------------------
  logic read_q; // Last cycle held a read
  int discarded_q; // Reads dropped on an error beat
  // Places one request, or idles when valid is low
  task automatic put(input logic valid, input master_type m, input logic w,
                     input logic [31:0] a);
    req_o <= '{valid: valid, master: m, write: w, addr: a};
  endtask : put
  // Bus idle from time zero
  initial req_o = '0;
  // Read data of an errored cycle is never used
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      read_q <= 1'b0;
      discarded_q <= 0;
    end else begin
      read_q <= req_o.valid && !req_o.write;
      if (rsp_err_i && read_q) begin
        discarded_q <= discarded_q + 1;
      end
    end
  end
endmodule : bus_master_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import addr_decode_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam master_type CO = MASTER_CORE;
  localparam master_type DM = MASTER_DMA;
  localparam logic [127:0] SLOTS = ~(128'h1 << 3); // Slot 3 holds no module
  typedef struct packed {
    logic [31:0] a;
    target_type t;
    logic e;
  } note_type;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic busy = 1'b0; // Flash command running
  logic [127:0] clk_en = ~(128'h1 << 9); // Slot 9 gated off
  logic rvalid = 1'b0;
  logic [31:0] rdata = 32'h0;
  req_type req;
  route_type route;
  logic rsp_valid, rsp_err, trim_valid;
  trim_type trim;
  note_type notes[$]; // Expected routes in issue order
  note_type n;
  int num_errors = 0;
  int total_checks = 0;
  int exp_disc = 0; // Errored reads the master must drop
  int i;
  logic busy_v = 1'b0;
  logic prev_err = 1'b0; // Error expected on the next beat
  logic [31:0] lfsr_q = 32'h13CF0A03;
  logic [31:0] d;
  // Free running clock, 25 ns
  always #12.5 mclk_i = ~mclk_i;
  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  bus_master_model mst_u (.mclk_i(mclk_i), .srst_i(srst_i), .rsp_err_i(rsp_err), .req_o(req));
  system_address_decoder #(
    .SRAM_L_FITTED(32'h0000_0800),
    .SRAM_U_FITTED(32'h0000_2000),
    .SLOT_IMPL(SLOTS)
  ) dut_u (
    .mclk_i(mclk_i), .srst_i(srst_i), .req_i(req), .flash_cmd_busy_i(busy),
    .slot_clk_en_i(clk_en), .flash_rvalid_i(rvalid), .flash_rdata_i(rdata),
    .route_o(route), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err),
    .trim_o(trim), .trim_valid_o(trim_valid)
  );
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  // Counts and reports one comparison
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // One request for one cycle, expectation queued
  task automatic go(input master_type m, input logic w, input logic [31:0] a,
                    input target_type t, input logic e);
    @(posedge mclk_i);
    busy <= busy_v;
    mst_u.put(1'b1, m, w, a);
    notes.push_back('{a, t, e});
    if (e && !w) exp_disc++;
  endtask : go
  // Drops the request line
  task automatic idle(input string name);
    @(posedge mclk_i);
    busy <= 1'b0;
    mst_u.put(1'b0, CO, 1'b0, 32'h0);
    repeat (2) @(posedge mclk_i);
    $display("test %s done", name);
  endtask : idle
  // ------------------------------------------------------------
  // Monitor: route in the request cycle, error beat one later
  // ------------------------------------------------------------
  always @(negedge mclk_i) begin
    if (srst_i) prev_err = 1'b0;
    else begin
      check("rsp_valid", 32'(rsp_valid), 32'(prev_err));
      check("rsp_err", 32'(rsp_err), 32'(prev_err));
      prev_err = 1'b0;
      if (req.valid === 1'b1) begin
        if (notes.size() == 0) check("note", 32'h0, 32'h1);
        else begin
          n = notes.pop_front();
          prev_err = n.e;
          check("route_valid", 32'(route.valid), 32'(!n.e));
          check("target", 32'(route.target), 32'(n.t));
          if (!n.e) check("offset", 32'(route.offset[11:0]), 32'(n.a[11:0]));
          if (n.t == TGT_FLASH) check("vector", 32'(route.vector), 32'(n.a < 32'hC4));
          if (n.a[31:12] == 20'h400FF || n.a[31:12] == 20'h4000F) begin
            check("full_atomic", 32'(route.full_atomic), 32'(n.a[31:12] == 20'h4000F));
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    check("trim_valid", 32'(trim_valid), 32'h0);
    // I/O window and GPIO paths
    go(CO, 0, 32'hF800_0010, TGT_GPIO_IO, 0);
    go(DM, 0, 32'hF800_0010, TGT_NONE, 1);
    go(DM, 0, 32'h400F_F004, TGT_GPIO_BRIDGE, 0);
    go(DM, 1, 32'h4000_F000, TGT_GPIO_BRIDGE, 0);
    go(CO, 0, 32'h4000_F008, TGT_GPIO_BRIDGE, 0);
    idle("gpio");
    // Bit alias region
    go(CO, 0, 32'h4400_1000, TGT_BIT_ALIAS, 0);
    go(DM, 0, 32'h4400_1000, TGT_NONE, 1);
    go(CO, 0, 32'h4408_0000, TGT_NONE, 1);
    go(CO, 1, 32'h4400_9000, TGT_NONE, 1);
    go(CO, 0, 32'h4400_3000, TGT_NONE, 1);
    go(CO, 0, 32'h4400_F000, TGT_BIT_ALIAS, 0);
    go(CO, 1, 32'h4407_F000, TGT_BIT_ALIAS, 0);
    idle("alias");
    // Flash range and fitted size
    go(CO, 0, 32'h0000_0000, TGT_FLASH, 0);
    go(DM, 0, 32'h0000_00C0, TGT_FLASH, 0);
    go(CO, 0, 32'h0000_00C4, TGT_FLASH, 0);
    go(CO, 0, 32'h0001_FFFC, TGT_FLASH, 0);
    go(CO, 0, 32'h0002_0000, TGT_NONE, 1);
    go(DM, 0, 32'h07FF_FFFC, TGT_NONE, 1);
    go(CO, 0, 32'h0800_0000, TGT_NONE, 1);
    idle("flash");
    // Read collision with a running command
    busy_v = 1'b1;
    go(CO, 0, 32'h0000_0100, TGT_NONE, 1);
    go(DM, 1, 32'h0000_0100, TGT_FLASH, 0);
    busy_v = 1'b0;
    idle("collision");
    // RAM halves and fitted size
    go(CO, 0, 32'h1FFF_F7FC, TGT_NONE, 1);
    go(DM, 1, 32'h1FFF_F800, TGT_SRAM_L, 0);
    go(DM, 0, 32'h1FFF_FFFC, TGT_SRAM_L, 0);
    go(CO, 0, 32'h2000_0000, TGT_SRAM_U, 0);
    go(CO, 1, 32'h2000_1FFC, TGT_SRAM_U, 0);
    go(CO, 0, 32'h2000_2000, TGT_NONE, 1);
    go(CO, 0, 32'h2000_3000, TGT_NONE, 1);
    idle("ram");
    // Bridge slots, private peripherals and reserved holes
    go(DM, 0, 32'h4000_8000, TGT_BRIDGE, 0);
    go(CO, 0, 32'h4000_3000, TGT_NONE, 1);
    go(CO, 0, 32'h4000_9000, TGT_NONE, 1);
    go(DM, 1, 32'h4007_F000, TGT_BRIDGE, 0);
    go(CO, 0, 32'h4008_0000, TGT_NONE, 1);
    go(CO, 0, 32'h4010_0000, TGT_NONE, 1);
    go(CO, 0, 32'h6000_0000, TGT_NONE, 1);
    go(CO, 0, 32'hE000_0000, TGT_PRIVATE, 0);
    go(DM, 0, 32'hE000_0000, TGT_NONE, 1);
    go(CO, 0, 32'hE010_0000, TGT_NONE, 1);
    idle("bridge");
    // Core only debug windows
    go(CO, 0, 32'hF000_0000, TGT_TRACE_BUF, 0);
    go(CO, 0, 32'hF000_1000, TGT_TRACE_WP, 0);
    go(CO, 0, 32'hF000_2000, TGT_ROM_TABLE, 0);
    go(CO, 1, 32'hF000_3FFC, TGT_MISC_CTRL, 0);
    go(DM, 0, 32'hF000_1000, TGT_NONE, 1);
    go(CO, 0, 32'hF000_4000, TGT_NONE, 1);
    idle("debug");
    check("discarded", 32'(mst_u.discarded_q), 32'(exp_disc));
    // Stray beat first, then the trim word
    @(posedge mclk_i);
    rvalid <= 1'b1;
    rdata <= lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    @(posedge mclk_i);
    rvalid <= 1'b0;
    @(negedge mclk_i);
    check("trim_valid", 32'(trim_valid), 32'h0);
    go(CO, 0, 32'h0000_03FC, TGT_FLASH, 0);
    @(posedge mclk_i);
    mst_u.put(1'b0, CO, 1'b0, 32'h0);
    d = lfsr_q;
    rvalid <= 1'b1;
    rdata <= d;
    @(posedge mclk_i);
    rvalid <= 1'b0;
    // Bounded wait for the capture
    for (i = 0; i < 4 && trim_valid !== 1'b1; i++) @(negedge mclk_i);
    if (i == 4) begin
      check("trim_timeout", 32'h0, 32'h1);
      test_done();
    end
    check("trim", {19'h0, trim}, {19'h0, d[16], d[20:17], d[31:24]});
    $display("test trim done");
    // Second reset clears the captured trim
    @(posedge mclk_i);
    srst_i <= 1'b1;
    @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    check("trim_valid", 32'(trim_valid), 32'h0);
    $display("test reset done");
    test_done();
  end
endmodule : tb_top
